// ### core/stm_pkg.sv
package stm_pkg;

    // Serial clock timing: minimum serial clock period and its half-period cycle count at clk_sys
    localparam int SYS_PERIOD_NS      = 4;
    localparam int SCK_MIN_PERIOD_NS  = 2000;
    localparam int SCK_HALF_CYCLES    = (SCK_MIN_PERIOD_NS / 2 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int DIV_W              = 16;

    // Word widths
    localparam int BYTE_W             = 8;
    localparam int WORD_W             = 16;
    localparam logic [4:0] BITS_8     = 5'h08;
    localparam logic [4:0] BITS_16    = 5'h10;

    // Tail mark tables: data-line level per half period of the serial clock,
    // clock line level per half period, sent from index 0 upward
    localparam int TAIL_LEN           = 4;
    localparam logic [3:0] HOLD_SDA   = 4'h3;
    localparam logic [3:0] HOLD_SCL   = 4'he;
    localparam logic [3:0] LATCH_SDA  = 4'hc;
    localparam logic [3:0] LATCH_SCL  = 4'he;

    // Buffer depth for staged transmit words
    localparam int BUF_DEPTH          = 2;

    // One staged transmit request
    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic              wide;
        logic              latch;
    } stm_word_s;

    typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_TAIL} stm_state_e;

endpackage

// ### core/stm_buf.sv
`timescale 1ns/10ps
// Two-entry buffer with valid/ready on both sides
module stm_buf
    import stm_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // Fill side
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire stm_word_s  in_word,
    // Drain side
    output logic            out_valid,
    input  wire logic       out_ready,
    output stm_word_s       out_word,
    // Clear
    input  wire logic       flush
);
    typedef struct packed {
        stm_word_s [1:0] mem;
        logic            wr;
        logic            rd;
        logic [1:0]      cnt;
    } stm_buf_s;

    stm_buf_s s_q, s_d;

    assign in_ready  = (s_q.cnt != 2'h2);
    assign out_valid = (s_q.cnt != 2'h0);
    assign out_word  = s_q.mem[s_q.rd];

    // Push and pop; flush drops all staged words
    always_comb begin
        logic push;
        logic pop;
        push = in_valid && in_ready;
        pop  = out_valid && out_ready;
        s_d  = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_word;
            s_d.wr          = ~s_q.wr;
        end
        if (pop) begin
            s_d.rd = ~s_q.rd;
        end
        s_d.cnt = 2'(s_q.cnt + {1'b0, push} - {1'b0, pop});
        if (flush) begin
            s_d.wr  = 1'b0;
            s_d.rd  = 1'b0;
            s_d.cnt = 2'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    count_range_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_q.cnt <= 2'h2) else $error("buffer count out of range");
    full_stall_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_q.cnt == 2'h2) |-> !in_ready) else $error("buffer accepts while full");

endmodule // stm_buf

// ### core/stm_tx.sv
`timescale 1ns/10ps
// What this block does
// - Tail enable, no continuous clock: two-wire mode
// - 8-bit sends low byte; 16-bit both
// - Tail kind bit picks hold or latch
// - Start flag write begins shifting data out
// - Last bit clears start, sets done request
// - Selected tail waveform follows the data
// - Tail busy flag high during tail output
// - Repeated load, start, wait sequences work
// - Single done source gated by enable bit
// - LSB first, tail directly after word
// - Control write with tail off reinitialises
module stm_tx
    import stm_pkg::*;
#(
    parameter int HALF_CYCLES = SCK_HALF_CYCLES
) (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                reset_n,
    // Module standby, active high, resets the unit like chip reset
    input  wire logic                module_standby,
    // Control configuration
    input  wire logic                tail_mark_enable,
    input  wire logic                continuous_clock_mode_bit,
    input  wire logic                word_width_select,
    input  wire logic                tail_kind_select,
    input  wire logic                idle_output_level,
    input  wire logic                open_drain_select,
    input  wire logic                control_write,
    // Data load and start
    input  wire logic [BYTE_W-1:0]   low_data_byte,
    input  wire logic [BYTE_W-1:0]   high_data_byte,
    input  wire logic                start_write,
    output logic                     start_ready,
    // Status and completion
    output logic                     transfer_start_flag,
    output logic                     tail_in_progress_flag,
    output logic                     transfer_done_request,
    input  wire logic                done_request_clear,
    input  wire logic                transfer_done_irq_enable,
    output logic                     irq,
    // Serial data pin, open drain capable
    input  wire logic                serial_data_in,
    output logic                     serial_data_out,
    output logic                     serial_data_oe,
    // Serial clock pin
    input  wire logic                serial_clock_in,
    output logic                     serial_clock_out,
    output logic                     serial_clock_oe
);
    typedef struct packed {
        stm_state_e        st;
        logic [WORD_W-1:0] sh;
        logic [4:0]        bits;
        logic              latch;
        logic [DIV_W-1:0]  div;
        logic              phase;
        logic [1:0]        tidx;
        logic              sda;
        logic              scl;
        logic              start;
        logic              done;
        logic              clk_s1;
        logic              clk_s2;
        logic              dat_s1;
        logic              dat_s2;
    } stm_tx_s;

    stm_tx_s   s_q, s_d;
    logic      ssb_mode;
    logic      reinit;
    logic      buf_valid;
    logic      buf_ready;
    stm_word_s buf_word;
    stm_word_s load_word;

    // Tail table lookup, shared by data and clock lines
    function automatic logic tail_bit(input logic lat, input logic clk_line,
                                      input logic [1:0] idx);
        logic [3:0] tab;
        if (lat) begin
            tab = clk_line ? LATCH_SCL : LATCH_SDA;
        end else begin
            tab = clk_line ? HOLD_SCL : HOLD_SDA;
        end
        return tab[idx];
    endfunction

    assign ssb_mode = tail_mark_enable && !continuous_clock_mode_bit;
    assign reinit   = control_write && !tail_mark_enable;

    // Word layout: wide picks both bytes, latch is written with the data
    always_comb begin
        load_word.data  = word_width_select ? {high_data_byte, low_data_byte}
                                            : {{BYTE_W{1'b0}}, low_data_byte};
        load_word.wide  = word_width_select;
        load_word.latch = tail_kind_select;
    end

    // Staging buffer keeps back-to-back starts while a frame is on the wire
    stm_buf #(.DEPTH(BUF_DEPTH)) u_buf (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .in_valid  (start_write && ssb_mode),
        .in_ready  (start_ready),
        .in_word   (load_word),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_word  (buf_word),
        .flush     (reinit || module_standby)
    );

    assign buf_ready = (s_q.st == ST_IDLE) && !reinit && !module_standby;

    // Sequencer: data bits, then tail table, on half periods of the serial clock
    always_comb begin
        logic tick;
        s_d        = s_q;
        s_d.clk_s1 = serial_clock_in;
        s_d.clk_s2 = s_q.clk_s1;
        s_d.dat_s1 = serial_data_in;
        s_d.dat_s2 = s_q.dat_s1;
        tick       = (s_q.div == DIV_W'(HALF_CYCLES - 1));
        s_d.div    = tick ? '0 : DIV_W'(s_q.div + 1'b1);
        case (s_q.st)
            ST_IDLE: begin
                s_d.div = '0;
                s_d.scl = 1'b1;
                if (buf_valid && buf_ready) begin
                    s_d.st    = ST_DATA;
                    s_d.sh    = buf_word.data;
                    s_d.bits  = buf_word.wide ? BITS_16 : BITS_8;
                    s_d.latch = buf_word.latch;
                    s_d.start = 1'b1;
                    s_d.phase = 1'b0;
                    s_d.scl   = 1'b0;
                    s_d.sda   = buf_word.data[0];
                end
            end
            ST_DATA: begin
                if (tick) begin
                    s_d.phase = ~s_q.phase;
                    s_d.scl   = ~s_q.phase;
                    if (s_q.phase) begin
                        if (s_q.bits == 5'h01) begin
                            s_d.st    = ST_TAIL;
                            s_d.start = 1'b0;
                            s_d.done  = 1'b1;
                            s_d.tidx  = 2'h0;
                            s_d.sda   = tail_bit(s_q.latch, 1'b0, 2'h0);
                            s_d.scl   = tail_bit(s_q.latch, 1'b1, 2'h0);
                        end else begin
                            s_d.sh   = {1'b0, s_q.sh[WORD_W-1:1]};
                            s_d.sda  = s_q.sh[1];
                            s_d.bits = 5'(s_q.bits - 1'b1);
                        end
                    end
                end
            end
            ST_TAIL: begin
                if (tick) begin
                    if (s_q.tidx == 2'(TAIL_LEN - 1)) begin
                        s_d.st  = ST_IDLE;
                        s_d.scl = 1'b1;
                        s_d.sda = idle_output_level;
                    end else begin
                        s_d.tidx = 2'(s_q.tidx + 1'b1);
                        s_d.sda  = tail_bit(s_q.latch, 1'b0, 2'(s_q.tidx + 1'b1));
                        s_d.scl  = tail_bit(s_q.latch, 1'b1, 2'(s_q.tidx + 1'b1));
                    end
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        // Idle data line follows the software level between frames
        if (s_q.st == ST_IDLE && s_d.st == ST_IDLE) begin
            s_d.sda = idle_output_level;
        end
        // Set wins over clear for the done request
        if (done_request_clear && !(s_q.st == ST_DATA && s_d.st == ST_TAIL)) begin
            s_d.done = 1'b0;
        end
        if (reinit || module_standby) begin
            s_d.st    = ST_IDLE;
            s_d.start = 1'b0;
            s_d.div   = '0;
            s_d.scl   = 1'b1;
            s_d.sda   = idle_output_level;
            if (module_standby) begin
                s_d.done = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_q     <= '0;
            s_q.st  <= ST_IDLE;
            s_q.sda <= 1'b1;
            s_q.scl <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs; start flag also covers a request still in the buffer
    assign transfer_start_flag   = s_q.start || buf_valid;
    assign tail_in_progress_flag = (s_q.st == ST_TAIL);
    assign transfer_done_request = s_q.done;
    assign irq                   = s_q.done && transfer_done_irq_enable;
    // Open drain releases the line for a one; push-pull drives always
    assign serial_data_out       = s_q.sda;
    assign serial_data_oe        = open_drain_select ? !s_q.sda : 1'b1;
    assign serial_clock_out      = s_q.scl;
    assign serial_clock_oe       = 1'b1;

    start_clears_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_q.st == ST_DATA && s_d.st == ST_TAIL) |=> (!s_q.start && s_q.done))
        else $error("start not cleared with done set");
    tail_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        tail_in_progress_flag |-> (s_q.st == ST_TAIL && !s_q.start))
        else $error("tail flag outside tail");
    tail_follows_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $fell(s_q.start) && !$past(reinit) && !$past(module_standby)
        |-> tail_in_progress_flag) else $error("tail not after data");
    lsb_first_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_q.st == ST_IDLE && s_d.st == ST_DATA) |=> (s_q.sda == s_q.sh[0]))
        else $error("first bit not lsb");
    width_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_q.st == ST_IDLE && s_d.st == ST_DATA)
        |=> (s_q.bits == ($past(buf_word.wide) ? BITS_16 : BITS_8)))
        else $error("bit count wrong for width");
    irq_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        irq |-> (transfer_done_request && transfer_done_irq_enable))
        else $error("irq without enabled request");
    reinit_idle_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        reinit |=> (s_q.st == ST_IDLE && !s_q.start))
        else $error("control write did not reinitialise");
    start_runs_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (buf_valid && buf_ready) |=> (s_q.st == ST_DATA && s_q.start))
        else $error("start did not begin transfer");

endmodule // stm_tx

// ### test/stm_slave_model.sv
`timescale 1ns/10ps
// Listening slave on the two-wire tail bus; it never drives either line
module stm_slave_model (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Resolved bus lines
    input  wire logic        scl,
    input  wire logic        sda,
    // Last frame heard
    output logic [31:0]      rx_bits,
    output logic [5:0]       rx_count,
    output logic             rx_tail,
    output logic [7:0]       frames
);
    logic [31:0] sh_q;
    logic [5:0]  n_q;
    logic        scl_q;
    logic        sda_q;

    // Bits taken at clock rises; a data edge with the clock high closes a frame.
    // Clock is only ever an input here, so no external clock is offered
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sh_q     <= '0;
            n_q      <= '0;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            rx_bits  <= '0;
            rx_count <= '0;
            rx_tail  <= 1'b0;
            frames   <= '0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (scl && !scl_q) begin
                sh_q[n_q[4:0]] <= sda;
                n_q            <= n_q + 6'h01;
            end else if (scl && scl_q && sda != sda_q && n_q != 6'h00) begin
                // Return to idle level also looks like an edge; empty frames ignored
                rx_bits  <= sh_q;
                rx_count <= n_q;
                rx_tail  <= sda;
                frames   <= frames + 8'h01;
                sh_q     <= '0;
                n_q      <= '0;
            end
        end
    end
endmodule // stm_slave_model

// ### test/stm_tx_tb.sv
`timescale 1ns/10ps
module stm_tx_tb;
    import stm_pkg::*;
    localparam int HC = 4;
    logic clk_sys = 0, reset_n = 0, module_standby = 0, tail_mark_enable = 1;
    logic continuous_clock_mode_bit = 0, word_width_select = 0, tail_kind_select = 0;
    logic idle_output_level = 1, open_drain_select = 1, control_write = 0;
    logic [7:0] low_data_byte = 8'h00, high_data_byte = 8'h00;
    logic start_write = 0, done_request_clear = 0, transfer_done_irq_enable = 0;
    logic start_ready, transfer_start_flag, tail_in_progress_flag, transfer_done_request, irq;
    logic sd_o, sd_oe, sc_o, sc_oe, sda_w, scl_w, rx_tail, ok;
    logic slave_rst_n = 1;
    logic [31:0] rx_bits;
    logic [5:0]  rx_count;
    logic [7:0]  frames;
    int bad_count = 0, checks = 0, n;

    // Open-drain data line with pull-up; clock line driven while enabled
    assign sda_w = sd_oe ? sd_o : 1'b1;
    assign scl_w = sc_oe ? sc_o : 1'b1;
    always #2 clk_sys = ~clk_sys;

    stm_tx #(.HALF_CYCLES(HC)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .module_standby(module_standby),
        .tail_mark_enable(tail_mark_enable), .control_write(control_write),
        .continuous_clock_mode_bit(continuous_clock_mode_bit),
        .word_width_select(word_width_select), .tail_kind_select(tail_kind_select),
        .idle_output_level(idle_output_level), .open_drain_select(open_drain_select),
        .low_data_byte(low_data_byte), .high_data_byte(high_data_byte),
        .start_write(start_write), .start_ready(start_ready),
        .transfer_start_flag(transfer_start_flag), .irq(irq),
        .tail_in_progress_flag(tail_in_progress_flag),
        .transfer_done_request(transfer_done_request),
        .done_request_clear(done_request_clear),
        .transfer_done_irq_enable(transfer_done_irq_enable),
        .serial_data_in(sda_w), .serial_data_out(sd_o), .serial_data_oe(sd_oe),
        .serial_clock_in(scl_w), .serial_clock_out(sc_o), .serial_clock_oe(sc_oe));

    stm_slave_model slave (
        .clk_sys(clk_sys), .reset_n(reset_n && slave_rst_n), .scl(scl_w), .sda(sda_w),
        .rx_bits(rx_bits), .rx_count(rx_count), .rx_tail(rx_tail), .frames(frames));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One start request; ok tells whether the buffer had room for it
    task automatic push(input logic [15:0] d, input logic w, input logic l);
        @(posedge clk_sys);
        low_data_byte     <= d[7:0];
        high_data_byte    <= d[15:8];
        word_width_select <= w;
        tail_kind_select  <= l;
        start_write       <= 1'b1;
        @(negedge clk_sys);
        ok = start_ready;
        @(posedge clk_sys);
        start_write <= 1'b0;
    endtask

    // Polling with the interrupt enable low is the documented way to wait
    task automatic wait_done();
        int i;
        for (i = 0; i < 400 && transfer_done_request !== 1'b1; i++) @(negedge clk_sys);
        if (i == 400) begin
            bad_count++;
            summarize();
        end
    endtask

    task automatic wait_frame(input logic [7:0] f, input logic [15:0] d, input logic w,
                              input logic l);
        int i;
        for (i = 0; i < 400 && frames === f; i++) @(negedge clk_sys);
        if (i == 400) begin
            bad_count++;
            summarize();
        end
        chk("frame bits", rx_bits, w ? {15'h0, !l, d} : {23'h0, !l, d[7:0]});
        chk("frame length", rx_count, w ? 32'd17 : 32'd9);
        chk("tail kind", rx_tail, l);
    endtask

    task automatic clear_done();
        @(posedge clk_sys);
        done_request_clear <= 1'b1;
        @(posedge clk_sys);
        done_request_clear <= 1'b0;
        @(negedge clk_sys);
        chk("done cleared", transfer_done_request, 0);
    endtask

    task automatic one(input logic [15:0] d, input logic w, input logic l, input logic e);
        logic [7:0] f;
        f = frames;
        transfer_done_irq_enable <= e;
        push(d, w, l);
        @(negedge clk_sys);
        chk("start flag", transfer_start_flag, 1);
        wait_done();
        chk("start dropped", transfer_start_flag, 0);
        chk("tail busy", tail_in_progress_flag, 1);
        chk("irq", irq, e);
        wait_frame(f, d, w, l);
        repeat (3 * HC) @(negedge clk_sys);
        chk("tail over", tail_in_progress_flag, 0);
        chk("idle data", sda_w, 1);
        chk("idle clock", scl_w, 1);
        clear_done();
        chk("irq low", irq, 0);
    endtask

    // Main sequence
    initial begin
        logic [7:0] f;
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(negedge clk_sys);
        chk("reset flags", {start_ready, transfer_start_flag, tail_in_progress_flag,
            transfer_done_request, sda_w, scl_w}, 6'h23);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            one(16'ha5c3 ^ (16'h1248 << k), k[1], k[0], k[0]);
        end
        $display("test modes done");
        for (int j = 0; j < 2; j++) begin
            continuous_clock_mode_bit <= (j == 0);
            tail_mark_enable          <= (j == 1) ? 1'b0 : 1'b1;
            push(16'h5a5a, 1'b0, 1'b0);
            repeat (3) @(negedge clk_sys);
            chk("refused start", transfer_start_flag, 0);
        end
        continuous_clock_mode_bit <= 1'b0;
        tail_mark_enable          <= 1'b1;
        $display("test refusal done");
        n  = 0;
        ok = 1'b1;
        while (ok && n < 6) begin
            push(16'h1111 * (n + 1), 1'b1, n[0]);
            if (ok) n++;
        end
        chk("buffer full", ok, 0);
        for (int i = 0; i < n; i++) begin
            f = frames;
            wait_frame(f, 16'h1111 * (i + 1), 1'b1, i[0]);
        end
        clear_done();
        $display("test back to back done");
        push(16'h00ff, 1'b1, 1'b0);
        repeat (20) @(posedge clk_sys);
        tail_mark_enable <= 1'b0;
        control_write    <= 1'b1;
        @(posedge clk_sys);
        control_write <= 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("reinit", {transfer_start_flag, tail_in_progress_flag}, 0);
        tail_mark_enable <= 1'b1;
        push(16'h00ff, 1'b1, 1'b1);
        repeat (20) @(posedge clk_sys);
        module_standby <= 1'b1;
        repeat (2) @(posedge clk_sys);
        module_standby <= 1'b0;
        @(negedge clk_sys);
        chk("standby", {transfer_start_flag, transfer_done_request}, 0);
        // Cut frames leave stray bits in the listener, so it starts afresh
        slave_rst_n <= 1'b0;
        @(posedge clk_sys);
        slave_rst_n <= 1'b1;
        @(negedge clk_sys);
        one(16'h0f0f, 1'b0, 1'b1, 1'b0);
        $display("test reinit done");
        summarize();
    end
endmodule // stm_tx_tb
